// *** wor_regs.svh ***
/*
 * Register offsets, field positions, reset values and timing counts of the wake-on-radio sleep timer.
 * Assumes inclusion by bare name from the timer modules; holds definitions only.
 */
`ifndef WOR_REGS_SVH
`define WOR_REGS_SVH

`define WOR_EVT_HIGH_OFS 6'h1E
`define WOR_EVT_LOW_OFS 6'h1F
`define WOR_CTRL_OFS 6'h20

`define WOR_EVT_HIGH_RST 8'h87
`define WOR_EVT_LOW_RST 8'h6B

`define WOR_CTRL_PD_BIT 7
`define WOR_CTRL_E1_MSB 6
`define WOR_CTRL_E1_LSB 4
`define WOR_CTRL_CAL_BIT 3
`define WOR_CTRL_RES_MSB 1
`define WOR_CTRL_RES_LSB 0

`define WOR_CTRL_PD_RST 1'h1
`define WOR_CTRL_E1_RST 3'h7
`define WOR_CTRL_CAL_RST 1'h1
`define WOR_CTRL_RES_RST 2'h0

`define WOR_RC_DIVIDE 750

`define WOR_E1_PERIODS_0 6'h04
`define WOR_E1_PERIODS_1 6'h06
`define WOR_E1_PERIODS_2 6'h08
`define WOR_E1_PERIODS_3 6'h0C
`define WOR_E1_PERIODS_4 6'h10
`define WOR_E1_PERIODS_5 6'h18
`define WOR_E1_PERIODS_6 6'h20
`define WOR_E1_PERIODS_7 6'h30

`define TIMEOUT_RESOLUTION_SELECT_SHIFT_0 5'h00
`define TIMEOUT_RESOLUTION_SELECT_SHIFT_1 5'h05
`define TIMEOUT_RESOLUTION_SELECT_SHIFT_2 5'h0A
`define TIMEOUT_RESOLUTION_SELECT_SHIFT_3 5'h0F

`define WOR_CAL_PERIODS 8'h10

`endif

// *** wor_pkg.sv ***
/*
 * Types shared by the wake-on-radio sleep timer files.
 * Assumes nothing beyond the constants header.
 */
package wor_pkg;

   // Gray codes along off, calibrate, run.
   typedef enum logic [1:0] {
      OSC_OFF = 2'h0,
      OSC_CAL = 2'h1,
      OSC_RUN = 2'h3
   } osc_state_e;

   typedef logic [5:0] reg_addr_t;
   typedef logic [7:0] reg_byte_t;

endpackage

// *** rc_tick_gen.sv ***
/*
 * Slow RC clock model: one tick every DIVIDE crystal clocks while enabled.
 * Assumes core_clk is the crystal clock and run comes from logic on that clock.
 */
`timescale 1ns/1ps
`include "wor_regs.svh"

module rc_tick_gen #(
   parameter int DIVIDE = `WOR_RC_DIVIDE
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire logic run,
   output logic tick
);

   logic [9:0] div_reg;
   logic [9:0] div_next;
   logic tick_reg;
   logic tick_next;

   always_comb begin
      div_next = div_reg;
      tick_next = 1'b0;
      if (!run) begin
         div_next = 10'h000;
      end else if (div_reg == 10'(DIVIDE - 1)) begin
         div_next = 10'h000;
         tick_next = 1'b1;
      end else begin
         div_next = div_reg + 10'h001;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         div_reg <= 10'h000;
         tick_reg <= 1'b0;
      end else begin
         div_reg <= div_next;
         tick_reg <= tick_next;
      end
   end

   assign tick = tick_reg;

endmodule

// *** wake_on_radio_timer.sv ***
/*
 * Wake-on-radio sleep timer: the two timeout bytes, the control register, the slow RC clock with its
 * power-down and calibration, and the periodic primary and secondary events.
 * Assumes a register port decoded elsewhere from the serial interface, core_clk as the crystal clock,
 * and the radio state machine on the same clock asking for counting through timer_run.
 */
`timescale 1ns/1ps
`include "wor_regs.svh"

module wake_on_radio_timer
   import wor_pkg::*;
#(
   parameter int RC_DIVIDE = `WOR_RC_DIVIDE,
   parameter logic [7:0] CAL_PERIODS = `WOR_CAL_PERIODS
) (
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire reg_addr_t reg_addr,
   input wire logic reg_wr,
   input wire reg_byte_t reg_wdata,
   input wire logic reg_rd,
   output reg_byte_t reg_rdata,
   input wire logic timer_run,
   output logic primary_event,
   output logic secondary_event,
   output logic osc_ready,
   output logic calib_busy
);

   reg_byte_t evt_high_reg;
   reg_byte_t evt_high_next;
   reg_byte_t evt_low_reg;
   reg_byte_t evt_low_next;
   logic slow_osc_power_down_reg;
   logic slow_osc_power_down_next;
   logic [2:0] secondary_delay_select_reg;
   logic [2:0] secondary_delay_select_next;
   logic slow_osc_calib_enable_reg;
   logic slow_osc_calib_enable_next;
   logic [1:0] timeout_resolution_select_reg;
   logic [1:0] timeout_resolution_select_next;
   reg_byte_t rdata_reg;
   reg_byte_t rdata_next;
   reg_byte_t ctrl_view;

   osc_state_e state_reg;
   osc_state_e state_next;
   logic [7:0] cal_cnt_reg;
   logic [7:0] cal_cnt_next;
   logic [30:0] period_cnt_reg;
   logic [30:0] period_cnt_next;
   logic [5:0] delay_cnt_reg;
   logic [5:0] delay_cnt_next;
   logic delay_pend_reg;
   logic delay_pend_next;
   logic prim_reg;
   logic prim_next;
   logic sec_reg;
   logic sec_next;

   logic rc_tick;
   logic [15:0] primary_timeout_value;
   logic [4:0] res_shift;
   logic [30:0] target;
   logic [5:0] delay_periods;

   rc_tick_gen #(
      .DIVIDE(RC_DIVIDE)
   ) u_rc_tick (
      .core_clk(core_clk),
      .sys_rst(sys_rst),
      .run(state_reg != OSC_OFF),
      .tick(rc_tick)
   );

   assign ctrl_view = {slow_osc_power_down_reg, secondary_delay_select_reg, slow_osc_calib_enable_reg, 1'b0,
                       timeout_resolution_select_reg};

   // Register writes and reads; the reserved control bit reads as zero.
   always_comb begin
      evt_high_next = evt_high_reg;
      evt_low_next = evt_low_reg;
      slow_osc_power_down_next = slow_osc_power_down_reg;
      secondary_delay_select_next = secondary_delay_select_reg;
      slow_osc_calib_enable_next = slow_osc_calib_enable_reg;
      timeout_resolution_select_next = timeout_resolution_select_reg;
      rdata_next = rdata_reg;
      if (reg_wr) begin
         unique case (reg_addr)
            `WOR_EVT_HIGH_OFS: begin
               evt_high_next = reg_wdata;
            end
            `WOR_EVT_LOW_OFS: begin
               evt_low_next = reg_wdata;
            end
            `WOR_CTRL_OFS: begin
               slow_osc_power_down_next = reg_wdata[`WOR_CTRL_PD_BIT];
               secondary_delay_select_next = reg_wdata[`WOR_CTRL_E1_MSB:`WOR_CTRL_E1_LSB];
               slow_osc_calib_enable_next = reg_wdata[`WOR_CTRL_CAL_BIT];
               timeout_resolution_select_next = reg_wdata[`WOR_CTRL_RES_MSB:`WOR_CTRL_RES_LSB];
            end
            default: begin
            end
         endcase
      end
      if (reg_rd) begin
         unique case (reg_addr)
            `WOR_EVT_HIGH_OFS: begin
               rdata_next = evt_high_reg;
            end
            `WOR_EVT_LOW_OFS: begin
               rdata_next = evt_low_reg;
            end
            `WOR_CTRL_OFS: begin
               rdata_next = ctrl_view;
            end
            default: begin
               rdata_next = 8'h00;
            end
         endcase
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         evt_high_reg <= `WOR_EVT_HIGH_RST;
         evt_low_reg <= `WOR_EVT_LOW_RST;
         slow_osc_power_down_reg <= `WOR_CTRL_PD_RST;
         secondary_delay_select_reg <= `WOR_CTRL_E1_RST;
         slow_osc_calib_enable_reg <= `WOR_CTRL_CAL_RST;
         timeout_resolution_select_reg <= `WOR_CTRL_RES_RST;
         rdata_reg <= 8'h00;
      end else begin
         evt_high_reg <= evt_high_next;
         evt_low_reg <= evt_low_next;
         slow_osc_power_down_reg <= slow_osc_power_down_next;
         secondary_delay_select_reg <= secondary_delay_select_next;
         slow_osc_calib_enable_reg <= slow_osc_calib_enable_next;
         timeout_resolution_select_reg <= timeout_resolution_select_next;
         rdata_reg <= rdata_next;
      end
   end

   assign primary_timeout_value = {evt_high_reg, evt_low_reg};

   always_comb begin
      unique case (timeout_resolution_select_reg)
         2'h0: res_shift = `TIMEOUT_RESOLUTION_SELECT_SHIFT_0;
         2'h1: res_shift = `TIMEOUT_RESOLUTION_SELECT_SHIFT_1;
         2'h2: res_shift = `TIMEOUT_RESOLUTION_SELECT_SHIFT_2;
         2'h3: res_shift = `TIMEOUT_RESOLUTION_SELECT_SHIFT_3;
      endcase
   end

   assign target = {15'h0000, primary_timeout_value} << res_shift;

   always_comb begin
      unique case (secondary_delay_select_reg)
         3'h0: delay_periods = `WOR_E1_PERIODS_0;
         3'h1: delay_periods = `WOR_E1_PERIODS_1;
         3'h2: delay_periods = `WOR_E1_PERIODS_2;
         3'h3: delay_periods = `WOR_E1_PERIODS_3;
         3'h4: delay_periods = `WOR_E1_PERIODS_4;
         3'h5: delay_periods = `WOR_E1_PERIODS_5;
         3'h6: delay_periods = `WOR_E1_PERIODS_6;
         3'h7: delay_periods = `WOR_E1_PERIODS_7;
      endcase
   end

   // Oscillator and event sequencing. A zero timeout is treated as one period so the timer cannot stall.
   always_comb begin
      state_next = state_reg;
      cal_cnt_next = cal_cnt_reg;
      period_cnt_next = period_cnt_reg;
      delay_cnt_next = delay_cnt_reg;
      delay_pend_next = delay_pend_reg;
      prim_next = 1'b0;
      sec_next = 1'b0;
      unique case (state_reg)
         OSC_OFF: begin
            period_cnt_next = 31'h00000000;
            delay_pend_next = 1'b0;
            if (!slow_osc_power_down_reg) begin
               cal_cnt_next = 8'h00;
               state_next = slow_osc_calib_enable_reg ? OSC_CAL : OSC_RUN;
            end
         end
         OSC_CAL: begin
            if (slow_osc_power_down_reg) begin
               state_next = OSC_OFF;
            end else if (!slow_osc_calib_enable_reg) begin
               state_next = OSC_RUN;
            end else if (rc_tick) begin
               cal_cnt_next = cal_cnt_reg + 8'h01;
               if (cal_cnt_reg == CAL_PERIODS - 8'h01) begin
                  state_next = OSC_RUN;
               end
            end
         end
         OSC_RUN: begin
            if (slow_osc_power_down_reg) begin
               state_next = OSC_OFF;
            end else if (!timer_run) begin
               // Stopping the timer restarts the next interval from zero rather than resuming it.
               period_cnt_next = 31'h00000000;
               delay_pend_next = 1'b0;
            end else if (rc_tick) begin
               // primary event at value times resolution
               if (period_cnt_reg + 31'h00000001 >= target) begin
                  period_cnt_next = 31'h00000000;
                  prim_next = 1'b1;
                  delay_pend_next = 1'b1;
                  delay_cnt_next = 6'h00;
               end else begin
                  period_cnt_next = period_cnt_reg + 31'h00000001;
               end
               if (delay_pend_reg) begin
                  // A new primary event restarts the count of a secondary that is still pending.
                  delay_cnt_next = prim_next ? 6'h00 : delay_cnt_reg + 6'h01;
                  if (delay_cnt_reg + 6'h01 == delay_periods) begin
                     sec_next = 1'b1;
                     delay_pend_next = prim_next;
                     delay_cnt_next = 6'h00;
                  end
               end
            end
         end
         default: begin
            state_next = OSC_OFF;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_reg <= OSC_OFF;
         cal_cnt_reg <= 8'h00;
         period_cnt_reg <= 31'h00000000;
         delay_cnt_reg <= 6'h00;
         delay_pend_reg <= 1'b0;
         prim_reg <= 1'b0;
         sec_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         cal_cnt_reg <= cal_cnt_next;
         period_cnt_reg <= period_cnt_next;
         delay_cnt_reg <= delay_cnt_next;
         delay_pend_reg <= delay_pend_next;
         prim_reg <= prim_next;
         sec_reg <= sec_next;
      end
   end

   // Status levels follow the next state so they line up with the state register.
   logic ready_reg;
   logic busy_reg;

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         ready_reg <= 1'b0;
         busy_reg <= 1'b0;
      end else begin
         ready_reg <= (state_next == OSC_RUN);
         busy_reg <= (state_next == OSC_CAL);
      end
   end

   assign reg_rdata = rdata_reg;
   assign primary_event = prim_reg;
   assign secondary_event = sec_reg;
   assign osc_ready = ready_reg;
   assign calib_busy = busy_reg;

endmodule

// *** wor_timer_asserts.sv ***
/*
 * Checker of the wake-on-radio timer port behaviour: register reads, oscillator levels and event pulses.
 * Assumes binding onto wake_on_radio_timer and that it sees only that module's ports.
 */
`timescale 1ns/1ps
module wor_timer_checker
   import wor_pkg::*;
(
   input wire logic core_clk,
   input wire logic sys_rst,
   input wire reg_addr_t reg_addr,
   input wire logic reg_wr,
   input wire reg_byte_t reg_wdata,
   input wire logic reg_rd,
   input wire reg_byte_t reg_rdata,
   input wire logic timer_run,
   input wire logic primary_event,
   input wire logic secondary_event,
   input wire logic osc_ready,
   input wire logic calib_busy
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (sys_rst);
   property p_rst_quiet;
      disable iff (1'b0) sys_rst |=> reg_rdata == 8'h00 && !primary_event && !secondary_event && !osc_ready;
   endproperty
   a_rst_quiet: assert property (p_rst_quiet) else $error("outputs not quiet after reset");
   property p_unmapped;
      reg_rd && !(reg_addr inside {6'h1E, 6'h1F, 6'h20}) |=> reg_rdata == 8'h00;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   property p_bit2;
      reg_rd && reg_addr == 6'h20 |=> !reg_rdata[2];
   endproperty
   a_bit2: assert property (p_bit2) else $error("reserved control bit reads one");
   property p_hi_rw;
      reg_wr && reg_addr == 6'h1E ##1 !reg_wr ##1 reg_rd && !reg_wr && reg_addr == 6'h1E |=> reg_rdata == $past(reg_wdata, 3);
   endproperty
   a_hi_rw: assert property (p_hi_rw) else $error("high timeout byte lost write");
   property p_lo_rw;
      reg_wr && reg_addr == 6'h1F ##1 !reg_wr ##1 reg_rd && !reg_wr && reg_addr == 6'h1F |=> reg_rdata == $past(reg_wdata, 3);
   endproperty
   a_lo_rw: assert property (p_lo_rw) else $error("low timeout byte lost write");
   property p_rd_hold;
      !reg_rd |=> $stable(reg_rdata);
   endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read data changed without read");
   property p_excl;
      calib_busy |-> !osc_ready;
   endproperty
   a_excl: assert property (p_excl) else $error("ready while calibrating");
   property p_pd_off;
      reg_wr && reg_addr == 6'h20 && reg_wdata[7] ##1 !reg_wr |-> ##2 (!osc_ready && !calib_busy);
   endproperty
   a_pd_off: assert property (p_pd_off) else $error("oscillator still up after power-down");
   property p_start_cal;
      reg_wr && reg_addr == 6'h20 && !reg_wdata[7] && reg_wdata[3] && !osc_ready && !calib_busy |-> ##[1:3] calib_busy;
   endproperty
   a_start_cal: assert property (p_start_cal) else $error("no calibration after power-up");
   property p_start_run;
      reg_wr && reg_addr == 6'h20 && !reg_wdata[7] && !reg_wdata[3] && !osc_ready && !calib_busy |-> ##[1:3] osc_ready;
   endproperty
   a_start_run: assert property (p_start_run) else $error("oscillator not ready without calibration");
   property p_pulses;
      primary_event || secondary_event |=> !$past(primary_event) || !primary_event;
   endproperty
   a_pulses: assert property (p_pulses) else $error("primary event wider than one cycle");
   property p_sec_pulse;
      secondary_event |=> !secondary_event;
   endproperty
   a_sec_pulse: assert property (p_sec_pulse) else $error("secondary event wider than one cycle");
   property p_no_evt_off;
      !osc_ready ##1 !osc_ready |-> !primary_event && !secondary_event;
   endproperty
   a_no_evt_off: assert property (p_no_evt_off) else $error("event while oscillator not running");
   c_cal: cover property (calib_busy ##1 !calib_busy);
   c_pri: cover property (primary_event);
   c_sec: cover property (secondary_event);
endmodule

bind wake_on_radio_timer wor_timer_checker i_wor_timer_checker (.core_clk(core_clk), .sys_rst(sys_rst),
   .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
   .timer_run(timer_run), .primary_event(primary_event), .secondary_event(secondary_event),
   .osc_ready(osc_ready), .calib_busy(calib_busy));

// *** tb.sv ***
/*
 * Self-checking bench of the wake-on-radio timer: registers, oscillator start-up and event timing.
 * Assumes the checker is bound separately; a short slow-clock divide keeps event periods small.
 */
`timescale 1ns/1ps
module tb;
   import wor_pkg::*;
   localparam int DIV = 4;
   localparam int CALP = 2;
   logic core_clk = 1'b0;
   logic sys_rst = 1'b1;
   reg_addr_t reg_addr = 6'h00;
   logic reg_wr = 1'b0;
   reg_byte_t reg_wdata = 8'h00;
   logic reg_rd = 1'b0;
   reg_byte_t reg_rdata;
   logic timer_run = 1'b0;
   logic primary_event, secondary_event, osc_ready, calib_busy;
   int fail_count = 0;
   int total_checks = 0;
   int tab[8] = '{4, 6, 8, 12, 16, 24, 32, 48};
   int n, m;
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin fail_count++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
   always #12.5 core_clk = ~core_clk;
   wake_on_radio_timer #(.RC_DIVIDE(DIV), .CAL_PERIODS(8'h02)) i_wake_on_radio_timer (.core_clk(core_clk),
      .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .timer_run(timer_run), .primary_event(primary_event),
      .secondary_event(secondary_event), .osc_ready(osc_ready), .calib_busy(calib_busy));
   task automatic wr(input reg_addr_t a, input reg_byte_t d);
      @(negedge core_clk);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge core_clk);
      reg_wr = 1'b0;
   endtask
   task automatic rd(input reg_addr_t a, input reg_byte_t e);
      @(negedge core_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge core_clk);
      reg_rd = 1'b0;
      `CHK(reg_rdata, e)
   endtask
   function automatic logic sig(input int w);
      case (w)
         0: return primary_event;
         1: return secondary_event;
         2: return calib_busy;
         default: return osc_ready;
      endcase
   endfunction
   // Counts cycles to the next high sample; a stuck signal returns lim.
   task automatic wait_sig(input int w, input int lim, output int k);
      k = 0;
      do begin
         @(negedge core_clk);
         k++;
      end while (sig(w) !== 1'b1 && k < lim);
   endtask
   // Powering down first clears the count, so a smaller timeout never has to wrap around.
   task automatic cfg(input reg_byte_t hi, input reg_byte_t lo, input reg_byte_t ctl);
      wr(6'h20, 8'h80);
      wr(6'h1E, hi);
      wr(6'h1F, lo);
      wr(6'h20, ctl);
   endtask
   task automatic t_regs;
      rd(6'h1E, 8'h87);
      rd(6'h1F, 8'h6B);
      rd(6'h20, 8'hF8);
      rd(6'h21, 8'h00);
      wr(6'h21, 8'hFF);
      wr(6'h1E, 8'h5A);
      rd(6'h1E, 8'h5A);
      wr(6'h1F, 8'hA5);
      rd(6'h1F, 8'hA5);
      wr(6'h20, 8'hFF);
      rd(6'h20, 8'hFB);
   endtask
   task automatic t_osc;
      cfg(8'h00, 8'h40, 8'h08);
      wait_sig(2, 10, n);
      `CHK(calib_busy, 1'b1)
      n = 0;
      while (calib_busy === 1'b1 && n < 100) begin
         @(negedge core_clk);
         n++;
      end
      // The slow tick is registered, so calibration ends one clock after its last tick period.
      `CHK(n, CALP * DIV + 1)
      `CHK(osc_ready, 1'b1)
      cfg(8'h00, 8'h40, 8'h00);
      wait_sig(3, 10, n);
      `CHK(calib_busy, 1'b0)
      `CHK(osc_ready, 1'b1)
   endtask
   task automatic t_delay;
      timer_run = 1'b1;
      for (int e = 0; e < 8; e++) begin
         wr(6'h20, {1'b0, e[2:0], 4'h0});
         wait_sig(0, 600, n);
         wait_sig(1, 600, n);
         `CHK(n, tab[e] * DIV)
         wait_sig(0, 600, m);
         `CHK(n + m, 64 * DIV)
      end
   endtask
   task automatic t_res;
      reg_byte_t v[4] = '{8'h05, 8'h02, 8'h01, 8'h00};
      int x[4] = '{20, 256, 4096, 4};
      for (int r = 0; r < 4; r++) begin
         cfg(8'h00, v[r], {6'h00, r[1:0]});
         wait_sig(0, 5000, n);
         wait_sig(0, 5000, n);
         `CHK(n, x[r])
      end
      // A primary on every tick keeps restarting the pending secondary, so none may appear.
      wait_sig(1, 40, n);
      `CHK(n, 40)
      cfg(8'h00, 8'h01, 8'h03);
      wait_sig(0, 5000, n);
      `CHK(n, 5000)
      timer_run = 1'b0;
      cfg(8'h00, 8'h05, 8'h00);
      wait_sig(0, 300, n);
      `CHK(n, 300)
   endtask
   task automatic results;
      if (fail_count == 0 && total_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge core_clk);
      fail_count++;
      results();
   end
   initial begin
      repeat (10) @(posedge core_clk);
      @(negedge core_clk);
      sys_rst = 1'b0;
      t_regs();
      t_osc();
      t_delay();
      t_res();
      results();
   end
endmodule
